// File: cmc_line_model.sv
// Far-side model: terminal line sender and tape deck character source.
module cmc_line_model (
  // Clock.
  input wire logic clk,
  // Deck motion from the controller.
  input wire cmc_pkg::cmc_motion_t motion,
  // Line side.
  output logic rx_valid,
  output logic [7:0] rx_char,
  output logic rx_local,
  // Tape side.
  output logic tape_char_done,
  output logic rd_valid,
  output logic [7:0] rd_char
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] tape_q[$];
  int unsigned chars_moved = 0;
  logic [2:0] tick_q = 3'h0;

  // Idle line shows the inverse of the last code, never a stale copy.
  initial
  begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
    rx_local = 1'b0;
    tape_char_done = 1'b0;
    rd_valid = 1'b0;
    rd_char = 8'h00;
  end

  // One code on the line: a single strobe cycle, then a short pause.
  task automatic send(input logic [7:0] c, input logic loc);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_char <= c;
    rx_local <= loc;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char <= ~c;
    rx_local <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // A character passes the head every eight cycles while the tape creeps.
  always @(posedge clk)
  begin
    tick_q <= tick_q + 3'h1;
    tape_char_done <= 1'b0;
    rd_valid <= 1'b0;
    if ((motion.fwd || motion.rev) && !motion.fast && tick_q == 3'h7)
    begin
      tape_char_done <= 1'b1;
      chars_moved <= chars_moved + 1;
      if (motion.fwd && tape_q.size() > 0)
      begin
        rd_valid <= 1'b1;
        rd_char <= tape_q.pop_front();
      end
    end
    else
      rd_char <= ~rd_char;
  end
endmodule

// File: cmc_pkg.sv
// Package holding constants and types for the cassette mode controller.
package cmc_pkg;

  // ----------------------------------------
  // Character codes
  // ----------------------------------------
  localparam logic [7:0] CH_DC1 = 8'h11;
  localparam logic [7:0] CH_DC2 = 8'h12;
  localparam logic [7:0] CH_DC3 = 8'h13;
  localparam logic [7:0] CH_DC4 = 8'h14;
  localparam logic [7:0] CH_SUB = 8'h1a;
  localparam logic [7:0] CH_ESC = 8'h1b;
  localparam logic [7:0] CH_DLE = 8'h10;
  localparam logic [7:0] CH_DEL = 8'h7f;
  localparam logic [7:0] CH_ZERO = 8'h30;

  // ----------------------------------------
  // Register map and reset values
  // ----------------------------------------
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int CTRL_RATE_LSB = 0; // 2 bits: 0..2 slow rates, 3 = 120 cps.
  localparam int CTRL_VAR_LSB = 2;  // 2 bits: 0 basic, 1 strappable, 2 extended.
  localparam int CTRL_STRAP = 4;    // Strapped alternative DC2 handling.
  localparam int CTRL_FWD_DC3 = 5;  // Forward DC3 read from tape.
  localparam int CTRL_ONLINE = 6;   // On-line or standby operation.

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int DEB_US = 10000;
  localparam int DEB_CYC = DEB_US * CLK_MHZ;
  localparam int GAP_US = 100;
  localparam int GAP_CYC = GAP_US * CLK_MHZ;
  localparam int BRK_US = 200000;
  localparam int BRK_CYC = BRK_US * CLK_MHZ;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_STOP = 4'b0000,
    ST_WRITE = 4'b0001,
    ST_READ = 4'b0010,
    ST_LEADER = 4'b0011,
    ST_ADV = 4'b0100,
    ST_BLKRW = 4'b0101,
    ST_REW = 4'b0110,
    ST_STEPF = 4'b0111,
    ST_STEPB = 4'b1000,
    ST_SLOWRW = 4'b1001,
    ST_GAP = 4'b1010,
    ST_SUBER = 4'b1011
  } cmc_state_t;

  typedef struct packed {
    logic lock;
    logic stop;
    logic write;
    logic adv;
    logic read;
    logic blkrw;
    logic rew;
  } cmc_btn_t;

  typedef struct packed {
    logic stop;
    logic write;
    logic read;
    logic lock;
    logic blkrw;
  } cmc_lamp_t;

  typedef struct packed {
    logic fwd;
    logic fast;
    logic rev;
    logic erase;
  } cmc_motion_t;

endpackage

// File: cmc_top.sv
// Cassette mode controller: buttons, line codes and tape events to modes and lamps.
//
// Contract
// RQ1: Write press at slow rate enters write.
// RQ2: Write entered only from stopped condition.
// RQ3: Stop, lock, advance or DC4 ends write.
// RQ4: Write at leader erases off leader, stops.
// RQ5: End of tape writing raises alarm, break.
// RQ6: Read press starts tape; online needs ready.
// RQ7: Read lamp on data, also during winding.
// RQ8: Stop or lock press ends read.
// RQ9: Write held plus advance erases while advancing.
// RQ10: Stop held, read tap steps one forward.
// RQ11: Stop held, block rewind tap backs one.
// RQ12: Back-up without data slow-rewinds until data/lock.
// RQ13: SUB in write backs up, erases; not 120.
// RQ14: Lock bars read/write and line codes; code mutes line codes only while on-line, and never local ones.
// RQ15: DC1 enters read when stopped.
// RQ16: Basic DC2 enters write; first not recorded.
// RQ17: Strapped DC2 never recorded, makes gaps.
// RQ18: Extended at 120 writes continuously, no leader stop.
// RQ19: ESC 0 block rewinds, not on end leader.
// RQ20: ESC DLE DEL rewinds fully.
// RQ21: Record codes in write except SUB, remote DC4.
// RQ22: DC3 from tape stops; forwarded if strapped.
// RQ23: Buttons synchronised, debounced, combinations first.
//
// Chosen here: the address map and the strobed register port.
module cmc_top #(
  parameter int DEB_N = cmc_pkg::DEB_CYC,
  parameter int BRK_N = cmc_pkg::BRK_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Front panel.
  input wire cmc_pkg::cmc_btn_t btn,
  output cmc_pkg::cmc_lamp_t lamp,
  // Line side characters, one-cycle strobes.
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_local,
  input wire logic line_ready_indication,
  output logic rec_valid,
  output logic [7:0] rec_char,
  output logic tx_valid,
  output logic [7:0] tx_char,
  // Tape sensing, from the deck logic.
  input wire logic tape_bot,
  input wire logic tape_eot,
  input wire logic tape_data,
  input wire logic tape_char_done,
  input wire logic tape_block_start,
  input wire logic tape_wr_tab,
  input wire logic rd_valid,
  input wire logic [7:0] rd_char,
  // Deck and terminal controls.
  output cmc_pkg::cmc_motion_t motion,
  output logic alarm,
  output logic line_break
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_q1, rst_n;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n) {rst_n, rst_q1} <= 2'b00;
    else {rst_n, rst_q1} <= {rst_q1, 1'b1};
  end

  // ----------------------------------------
  // Button sync and debounce
  // ----------------------------------------
  // Two flops per button, then a settle counter; a change is only taken once stable.
  logic [6:0] b_s1_q, b_s2_q, b_deb_q, b_prev_q;
  logic [31:0] deb_cnt_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      b_s1_q <= 7'h00;
      b_s2_q <= 7'h00;
      b_deb_q <= 7'h00;
      b_prev_q <= 7'h00;
      deb_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      b_s1_q <= btn; // RQ23
      b_s2_q <= b_s1_q;
      b_prev_q <= b_deb_q;
      if (b_s2_q == b_deb_q) deb_cnt_q <= 32'h0000_0000;
      else if (deb_cnt_q >= 32'(DEB_N - 1))
      begin
        b_deb_q <= b_s2_q; // RQ23
        deb_cnt_q <= 32'h0000_0000;
      end
      else deb_cnt_q <= deb_cnt_q + 32'h0000_0001;
    end
  end

  cmc_pkg::cmc_btn_t bh, bp;
  assign bh = b_deb_q;
  assign bp = b_deb_q & ~b_prev_q;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic [7:0] ctrl_q;
  logic rate_fast, v_basic, v_strap, v_ext, strap, online;
  assign rate_fast = ctrl_q[cmc_pkg::CTRL_RATE_LSB +: 2] == 2'h3;
  assign v_basic = ctrl_q[cmc_pkg::CTRL_VAR_LSB +: 2] == 2'h0;
  assign v_strap = ctrl_q[cmc_pkg::CTRL_VAR_LSB +: 2] == 2'h1;
  assign v_ext = ctrl_q[cmc_pkg::CTRL_VAR_LSB +: 2] == 2'h2;
  assign strap = ctrl_q[cmc_pkg::CTRL_STRAP] & ~v_basic;
  assign online = ctrl_q[cmc_pkg::CTRL_ONLINE];

  // ----------------------------------------
  // Line code decode
  // ----------------------------------------
  logic lock_q, esc_q, escdle_q, dc2_seen_q, rew_held_q;
  cmc_pkg::cmc_state_t st_q, st_d;
  logic rx_ok, c_dc1, c_dc2, c_dc4, c_sub, c_esc0, c_rew;
  // While on-line, lock mutes only codes arriving from the line; local keyboard still acts.
  assign rx_ok = rx_valid & ~(lock_q & online & ~rx_local); // RQ14
  assign c_dc1 = rx_ok & rx_char == cmc_pkg::CH_DC1;
  assign c_dc2 = rx_ok & rx_char == cmc_pkg::CH_DC2;
  assign c_dc4 = rx_ok & rx_char == cmc_pkg::CH_DC4;
  assign c_sub = rx_ok & rx_char == cmc_pkg::CH_SUB;
  assign c_esc0 = rx_ok & esc_q & rx_char == cmc_pkg::CH_ZERO; // RQ19
  assign c_rew = rx_ok & escdle_q & rx_char == cmc_pkg::CH_DEL; // RQ20

  // ----------------------------------------
  // Mode decisions
  // ----------------------------------------
  // Two-button combinations are decoded ahead of single presses.
  logic is_stop, on_leader, combo_f, combo_b, erase_adv;
  logic wr_req, rd_req, dc3_hit, wr_ok;
  assign is_stop = st_q == cmc_pkg::ST_STOP;
  assign on_leader = tape_bot;
  assign combo_f = bh.stop & bp.read & ~rate_fast; // RQ10 RQ23
  assign combo_b = bh.stop & bp.blkrw; // RQ11 RQ23
  assign erase_adv = bh.write & bp.adv; // RQ9 RQ23
  assign wr_ok = tape_wr_tab & ~lock_q;
  assign wr_req = (bp.write & ~bh.adv & (~rate_fast | v_ext)) | c_dc2; // RQ1 RQ18
  assign rd_req = (bp.read & ~bh.stop & (~online | line_ready_indication)) | c_dc1; // RQ6 RQ15
  assign dc3_hit = rd_valid & rd_char == cmc_pkg::CH_DC3 & st_q == cmc_pkg::ST_READ;

  logic [31:0] tim_q;
  logic tim_done;
  assign tim_done = tim_q == 32'h0000_0000;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      cmc_pkg::ST_STOP:
      begin
        if (combo_b) st_d = cmc_pkg::ST_STEPB; // RQ11
        else if (combo_f && !lock_q) st_d = cmc_pkg::ST_STEPF; // RQ10
        else if (erase_adv && wr_ok) st_d = cmc_pkg::ST_ADV; // RQ9
        else if (bh.adv) st_d = cmc_pkg::ST_ADV;
        else if (wr_req && wr_ok && on_leader) st_d = cmc_pkg::ST_LEADER; // RQ2 RQ4
        else if (wr_req && wr_ok) st_d = (c_dc2 && strap) ? cmc_pkg::ST_GAP : cmc_pkg::ST_WRITE;
        else if (rd_req && !lock_q) st_d = cmc_pkg::ST_READ; // RQ6 RQ14
        else if (c_rew || (bp.rew && (v_basic || !lock_q))) st_d = cmc_pkg::ST_REW; // RQ20
        else if ((c_esc0 || bp.blkrw) && !tape_eot) st_d = cmc_pkg::ST_BLKRW; // RQ19
      end
      cmc_pkg::ST_WRITE:
      begin
        if (bp.stop || bp.lock || bp.adv || (c_dc4 && !rx_local)) st_d = cmc_pkg::ST_STOP; // RQ3
        else if (c_sub && !rate_fast) st_d = cmc_pkg::ST_SUBER; // RQ13
        else if (c_dc2 && strap) st_d = cmc_pkg::ST_GAP; // RQ17
      end
      cmc_pkg::ST_LEADER:
      begin
        if (bp.stop || bp.lock) st_d = cmc_pkg::ST_STOP;
        else if (!tape_bot && !(v_ext && rate_fast)) st_d = cmc_pkg::ST_WRITE; // RQ4 RQ18
      end
      cmc_pkg::ST_GAP: if (tim_done) st_d = cmc_pkg::ST_WRITE; // RQ17
      cmc_pkg::ST_SUBER: if (tape_char_done) st_d = cmc_pkg::ST_WRITE; // RQ13
      cmc_pkg::ST_READ:
      begin
        if (bp.stop || bp.lock || dc3_hit || tape_eot) st_d = cmc_pkg::ST_STOP; // RQ8 RQ22
      end
      cmc_pkg::ST_ADV: if (!bh.adv) st_d = cmc_pkg::ST_STOP;
      cmc_pkg::ST_STEPF: if (tape_char_done) st_d = cmc_pkg::ST_STOP; // RQ10
      cmc_pkg::ST_STEPB:
      begin
        if (tape_char_done) st_d = cmc_pkg::ST_STOP; // RQ11
        else if (!tape_data) st_d = cmc_pkg::ST_SLOWRW; // RQ12
      end
      cmc_pkg::ST_SLOWRW:
      begin
        if (tape_data || bp.lock || tape_bot) st_d = cmc_pkg::ST_STOP; // RQ12
      end
      cmc_pkg::ST_BLKRW:
      begin
        if (bp.stop || bp.lock || tape_bot || tape_block_start) st_d = cmc_pkg::ST_STOP;
      end
      cmc_pkg::ST_REW:
      begin
        if (tape_bot || bp.lock || (v_basic && rew_held_q && !bh.rew)) st_d = cmc_pkg::ST_STOP;
        else if (bh.blkrw && bp.stop) st_d = cmc_pkg::ST_STOP;
      end
      default: st_d = cmc_pkg::ST_STOP;
    endcase
    // A SUB in the stopped condition is a back-up request too.
    if (st_q == cmc_pkg::ST_STOP && c_sub && !lock_q && !rate_fast) st_d = cmc_pkg::ST_STEPB;
  end

  // ----------------------------------------
  // State, lock and sequence registers
  // ----------------------------------------
  logic [31:0] brk_q;
  logic wr_alarm, eot_hit;
  assign eot_hit = tape_eot & st_q == cmc_pkg::ST_WRITE;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= cmc_pkg::ST_STOP;
      lock_q <= 1'b0;
      esc_q <= 1'b0;
      escdle_q <= 1'b0;
      dc2_seen_q <= 1'b0;
      rew_held_q <= 1'b0;
      tim_q <= 32'h0000_0000;
      brk_q <= 32'h0000_0000;
      ctrl_q <= cmc_pkg::CTRL_RST;
    end
    else
    begin
      // End of tape alone never leaves write mode, so stop, lock and DC4 still end it.
      st_q <= st_d;
      if (bp.lock) lock_q <= ~lock_q; // RQ14
      if (rx_ok)
      begin
        esc_q <= rx_char == cmc_pkg::CH_ESC;
        escdle_q <= esc_q & rx_char == cmc_pkg::CH_DLE;
      end
      // The DC2 that opens write mode counts as the first one.
      if (st_q == cmc_pkg::ST_STOP && !c_dc2) dc2_seen_q <= 1'b0;
      else if (c_dc2) dc2_seen_q <= 1'b1; // RQ16
      // Only a panel rewind on the basic variant needs the button held.
      if (st_q == cmc_pkg::ST_STOP) rew_held_q <= bp.rew & ~c_rew; // RQ20
      if (st_d == cmc_pkg::ST_GAP && st_q != cmc_pkg::ST_GAP) tim_q <= 32'(cmc_pkg::GAP_CYC);
      else if (!tim_done) tim_q <= tim_q - 32'h0000_0001;
      if (eot_hit && brk_q == 32'h0000_0000) brk_q <= 32'(BRK_N); // RQ5
      else if (brk_q != 32'h0000_0000 && !eot_hit) brk_q <= brk_q - 32'h0000_0001;
      if (reg_wr && reg_addr == cmc_pkg::ADR_CTRL) ctrl_q <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic rec_go, fwd_go;
  assign wr_alarm = (bp.write | c_dc2) & ~tape_wr_tab; // RQ1
  // First DC2 of a session and all strapped DC2s are swallowed.
  assign rec_go = rx_valid & st_q == cmc_pkg::ST_WRITE & rx_char != cmc_pkg::CH_SUB
    & !(rx_char == cmc_pkg::CH_DC4 & !rx_local)
    & !(rx_char == cmc_pkg::CH_DC2 & (strap | !dc2_seen_q)); // RQ16 RQ17 RQ21
  assign fwd_go = rd_valid & (rd_char != cmc_pkg::CH_DC3 | (strap & ctrl_q[cmc_pkg::CTRL_FWD_DC3]));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rec_valid <= 1'b0;
      rec_char <= 8'h00;
      tx_valid <= 1'b0;
      tx_char <= 8'h00;
      alarm <= 1'b0;
      line_break <= 1'b0;
      lamp <= '0;
      motion <= '0;
      reg_rdata <= 8'h00;
    end
    else
    begin
      rec_valid <= rec_go; // RQ21
      rec_char <= rx_char;
      tx_valid <= fwd_go; // RQ22
      tx_char <= rd_char;
      alarm <= wr_alarm | eot_hit; // RQ5
      line_break <= brk_q != 32'h0000_0000; // RQ5
      lamp.stop <= st_d == cmc_pkg::ST_STOP; // RQ3 RQ14
      lamp.write <= st_d inside {cmc_pkg::ST_WRITE, cmc_pkg::ST_LEADER,
        cmc_pkg::ST_GAP, cmc_pkg::ST_SUBER};
      lamp.read <= (st_q == cmc_pkg::ST_READ) | (tape_data &
        st_q inside {cmc_pkg::ST_ADV, cmc_pkg::ST_REW, cmc_pkg::ST_BLKRW}); // RQ7
      lamp.lock <= lock_q;
      lamp.blkrw <= tape_bot & st_d == cmc_pkg::ST_STOP;
      // Write mode parks the tape; the deck steps it per recorded character.
      motion.fwd <= st_d inside {cmc_pkg::ST_READ, cmc_pkg::ST_LEADER,
        cmc_pkg::ST_ADV, cmc_pkg::ST_STEPF, cmc_pkg::ST_GAP} & !eot_hit; // RQ4
      motion.fast <= st_d inside {cmc_pkg::ST_ADV, cmc_pkg::ST_REW, cmc_pkg::ST_BLKRW};
      motion.rev <= st_d inside {cmc_pkg::ST_REW, cmc_pkg::ST_BLKRW, cmc_pkg::ST_STEPB,
        cmc_pkg::ST_SLOWRW, cmc_pkg::ST_SUBER}; // RQ12
      motion.erase <= (st_d inside {cmc_pkg::ST_LEADER, cmc_pkg::ST_GAP, cmc_pkg::ST_SUBER})
        | (st_d == cmc_pkg::ST_ADV & ((bh.write & tape_wr_tab)
        | (st_q == cmc_pkg::ST_ADV & motion.erase))); // RQ9
      if (reg_rd && reg_addr == cmc_pkg::ADR_CTRL) reg_rdata <= ctrl_q;
      else if (reg_rd && reg_addr == cmc_pkg::ADR_STAT) reg_rdata <= {3'h0, lock_q, st_q};
      else reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_wr_only_stop;
    @(posedge clk) disable iff (!rst_n)
      (st_q == cmc_pkg::ST_READ) |=> st_q != cmc_pkg::ST_WRITE;
  endproperty
  a_wr_only_stop: assert property (p_wr_only_stop) else $error("write from read"); // RQ2

  property p_dc4_stop;
    @(posedge clk) disable iff (!rst_n)
      (st_q == cmc_pkg::ST_WRITE && c_dc4 && !rx_local && !tape_eot) |=> st_q == cmc_pkg::ST_STOP;
  endproperty
  a_dc4_stop: assert property (p_dc4_stop) else $error("DC4 did not stop write"); // RQ3

  property p_read_stop;
    @(posedge clk) disable iff (!rst_n)
      (st_q == cmc_pkg::ST_READ && bp.stop) |=> ##1 lamp.stop;
  endproperty
  a_read_stop: assert property (p_read_stop) else $error("stop lamp missing"); // RQ8

  property p_lock_noread;
    @(posedge clk) disable iff (!rst_n)
      (lock_q && st_q == cmc_pkg::ST_STOP) |=> st_q != cmc_pkg::ST_READ;
  endproperty
  a_lock_noread: assert property (p_lock_noread) else $error("read under lock"); // RQ14

  property p_dc1_read;
    @(posedge clk) disable iff (!rst_n)
      (is_stop && c_dc1 && !lock_q && bh == '0) |=> st_q == cmc_pkg::ST_READ;
  endproperty
  a_dc1_read: assert property (p_dc1_read) else $error("DC1 ignored"); // RQ15

  property p_sub_norec;
    @(posedge clk) disable iff (!rst_n)
      (rx_valid && rx_char == cmc_pkg::CH_SUB) |=> !rec_valid;
  endproperty
  a_sub_norec: assert property (p_sub_norec) else $error("SUB recorded"); // RQ21

  property p_eot_alarm;
    @(posedge clk) disable iff (!rst_n)
      (eot_hit && st_d == cmc_pkg::ST_WRITE) |=> alarm && lamp.write;
  endproperty
  a_eot_alarm: assert property (p_eot_alarm) else $error("no alarm at end of tape"); // RQ5

  property p_dc3_stop;
    @(posedge clk) disable iff (!rst_n)
      dc3_hit |=> st_q == cmc_pkg::ST_STOP ##1 lamp.stop;
  endproperty
  a_dc3_stop: assert property (p_dc3_stop) else $error("DC3 did not stop"); // RQ22

endmodule

// File: cmc_top_test.sv
// Testbench for the cassette mode controller: panel, line and register scenarios.
module cmc_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam cmc_pkg::cmc_btn_t B_LOCK = 7'h40;
  localparam cmc_pkg::cmc_btn_t B_STOP = 7'h20;
  localparam cmc_pkg::cmc_btn_t B_WR = 7'h10;
  localparam cmc_pkg::cmc_btn_t B_ADV = 7'h08;
  localparam cmc_pkg::cmc_btn_t B_RD = 7'h04;
  localparam cmc_pkg::cmc_btn_t B_BRW = 7'h02;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  cmc_pkg::cmc_btn_t btn = '0;
  logic line_ready_indication = 1'b1;
  logic tape_bot = 1'b0;
  logic tape_eot = 1'b0;
  logic tape_data = 1'b1;
  logic tape_wr_tab = 1'b1;
  logic rx_valid, rx_local, rec_valid, tx_valid, tape_char_done, rd_valid, alarm, line_break;
  logic [7:0] reg_rdata, rx_char, rec_char, tx_char, rd_char, rd;
  cmc_pkg::cmc_lamp_t lamp;
  cmc_pkg::cmc_motion_t motion;
  logic [7:0] rec_n = 8'h00;
  logic [7:0] rec_last = 8'h00;
  logic [7:0] tx_dc3 = 8'h00;
  logic seen_re = 1'b0;
  logic seen_rl = 1'b0;
  logic seen_al = 1'b0;
  logic tape_block_start = 1'b0;
  logic [7:0] tx_last = 8'h00;
  int miscompares = 0;
  int num_checks = 0;
  int unsigned m0;

  // Short debounce and break so a press costs four stages of a dozen cycles.
  cmc_top #(.DEB_N(4), .BRK_N(8)) u_dut (
    .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .btn, .lamp,
    .rx_valid, .rx_char, .rx_local, .line_ready_indication, .rec_valid, .rec_char,
    .tx_valid, .tx_char, .tape_bot, .tape_eot, .tape_data, .tape_char_done,
    .tape_block_start, .tape_wr_tab, .rd_valid, .rd_char, .motion, .alarm,
    .line_break
  );

  cmc_line_model u_line (
    .clk, .motion, .rx_valid, .rx_char, .rx_local, .tape_char_done, .rd_valid, .rd_char
  );

  always #10 clk = ~clk;

  // Tallies of recorded codes, forwarded stop codes and seen conditions.
  always @(posedge clk)
  begin
    if (rec_valid === 1'b1)
    begin
      rec_n <= rec_n + 8'h01;
      rec_last <= rec_char;
    end
    if (tx_valid === 1'b1 && tx_char === cmc_pkg::CH_DC3)
      tx_dc3 <= tx_dc3 + 8'h01;
    if (motion.rev === 1'b1 && motion.erase === 1'b1)
      seen_re <= 1'b1;
    if (lamp.read === 1'b1)
      seen_rl <= 1'b1;
    if (alarm === 1'b1)
      seen_al <= 1'b1;
    if (tx_valid === 1'b1)
      tx_last <= tx_char;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  // Holds one button, taps another, then releases both; each stage outlasts debounce.
  task automatic press(input cmc_pkg::cmc_btn_t hold, input cmc_pkg::cmc_btn_t tap);
    btn <= hold;
    repeat (12) @(posedge clk);
    btn <= hold | tap;
    repeat (12) @(posedge clk);
    btn <= hold;
    repeat (12) @(posedge clk);
    btn <= '0;
    repeat (12) @(posedge clk);
  endtask

  task automatic fin(input string n);
    $display("test %s done", n);
  endtask

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog: the sequence needs about 1000 cycles.
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    wrap_up();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rreg(cmc_pkg::ADR_CTRL, rd);
    chk(rd, cmc_pkg::CTRL_RST);
    wreg(4'h7, 8'h5a);
    rreg(4'h7, rd);
    chk(rd, 8'h00);
    chk({3'h0, lamp}, 8'h10);
    fin("registers");
    press('0, B_WR);
    chk({3'h0, lamp}, 8'h08);
    press('0, B_RD);
    chk({3'h0, lamp}, 8'h08);
    u_line.send(8'h41, 1'b0);
    chk(rec_n, 8'h01);
    chk(rec_last, 8'h41);
    m0 = u_line.chars_moved;
    u_line.send(cmc_pkg::CH_SUB, 1'b0);
    repeat (20) @(posedge clk);
    chk(rec_n, 8'h01);
    chk(8'(u_line.chars_moved - m0), 8'h01);
    chk({7'h0, seen_re}, 8'h01);
    u_line.send(cmc_pkg::CH_DC4, 1'b0);
    chk({3'h0, lamp}, 8'h10);
    chk(rec_n, 8'h01);
    fin("write press");
    u_line.send(cmc_pkg::CH_DC2, 1'b0);
    chk({3'h0, lamp}, 8'h08);
    chk(rec_n, 8'h01);
    u_line.send(cmc_pkg::CH_DC2, 1'b0);
    chk(rec_last, cmc_pkg::CH_DC2);
    u_line.send(cmc_pkg::CH_DC4, 1'b1);
    chk(rec_last, cmc_pkg::CH_DC4);
    chk({3'h0, lamp}, 8'h08);
    u_line.send(cmc_pkg::CH_DC4, 1'b0);
    chk({3'h0, lamp}, 8'h10);
    fin("line write");
    press('0, B_WR);
    btn <= B_ADV;
    repeat (12) @(posedge clk);
    chk({4'h0, motion & 4'h9}, 8'h08);
    btn <= '0;
    repeat (12) @(posedge clk);
    chk({3'h0, lamp}, 8'h10);
    btn <= B_WR;
    repeat (12) @(posedge clk);
    btn <= B_WR | B_ADV;
    repeat (12) @(posedge clk);
    chk({4'h0, motion & 4'h9}, 8'h09);
    btn <= '0;
    repeat (12) @(posedge clk);
    press('0, B_STOP);
    fin("advance");
    tape_wr_tab <= 1'b0;
    press('0, B_WR);
    chk({7'h0, seen_al}, 8'h01);
    chk({3'h0, lamp}, 8'h10);
    tape_wr_tab <= 1'b1;
    fin("write tab");
    u_line.tape_q.push_back(8'h41);
    u_line.tape_q.push_back(cmc_pkg::CH_DC3);
    u_line.send(cmc_pkg::CH_DC1, 1'b0);
    chk({7'h0, lamp.stop}, 8'h00);
    repeat (40) @(posedge clk);
    chk({3'h0, lamp}, 8'h10);
    chk(tx_dc3, 8'h00);
    chk(tx_last, 8'h41);
    chk({7'h0, seen_rl}, 8'h01);
    fin("remote read");
    press('0, B_LOCK);
    chk({3'h0, lamp}, 8'h12);
    wreg(cmc_pkg::ADR_CTRL, 8'h40);
    u_line.send(cmc_pkg::CH_DC1, 1'b0);
    chk({3'h0, lamp}, 8'h12);
    press('0, B_RD);
    chk({3'h0, lamp}, 8'h12);
    press('0, B_LOCK);
    chk({3'h0, lamp}, 8'h10);
    fin("lock");
    line_ready_indication <= 1'b0;
    press('0, B_RD);
    chk({3'h0, lamp}, 8'h10);
    line_ready_indication <= 1'b1;
    press('0, B_RD);
    chk({7'h0, lamp.stop}, 8'h00);
    press('0, B_STOP);
    chk({3'h0, lamp}, 8'h10);
    wreg(cmc_pkg::ADR_CTRL, 8'h00);
    fin("line ready");
    m0 = u_line.chars_moved;
    press(B_STOP, B_RD);
    chk(8'(u_line.chars_moved - m0), 8'h01);
    press(B_STOP, B_BRW);
    chk(8'(u_line.chars_moved - m0), 8'h02);
    chk({3'h0, lamp}, 8'h10);
    tape_data <= 1'b0;
    press(B_STOP, B_BRW);
    chk({4'h0, motion & 4'h2}, 8'h02);
    tape_data <= 1'b1;
    repeat (4) @(posedge clk);
    chk({3'h0, lamp}, 8'h10);
    fin("single step");
    u_line.send(cmc_pkg::CH_ESC, 1'b0);
    u_line.send(cmc_pkg::CH_ZERO, 1'b0);
    chk({4'h0, motion & 4'h6}, 8'h06);
    tape_block_start <= 1'b1;
    @(posedge clk);
    tape_block_start <= 1'b0;
    repeat (4) @(posedge clk);
    chk({3'h0, lamp}, 8'h10);
    u_line.send(cmc_pkg::CH_ESC, 1'b0);
    u_line.send(cmc_pkg::CH_DLE, 1'b0);
    u_line.send(cmc_pkg::CH_DEL, 1'b0);
    chk({4'h0, motion & 4'h2}, 8'h02);
    tape_bot <= 1'b1;
    repeat (12) @(posedge clk);
    chk({3'h0, lamp}, 8'h11);
    press('0, B_WR);
    chk({4'h0, motion & 4'h9}, 8'h09);
    tape_bot <= 1'b0;
    repeat (12) @(posedge clk);
    chk({3'h0, lamp.write, motion}, 8'h10);
    fin("rewind and leader");
    tape_eot <= 1'b1;
    repeat (4) @(posedge clk);
    chk({5'h0, alarm, line_break, lamp.write}, 8'h07);
    tape_eot <= 1'b0;
    press('0, B_STOP);
    fin("end of tape");
    wrap_up();
  end
endmodule
